/* common/mppio_pkg.sv */
// Package of register map, field positions and carrier types for the parallel I/O block
package mppio_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_FIRST_DATA     = 6'h00;
    localparam logic [5:0] IDX_FIRST_DIR      = 6'h01;
    localparam logic [5:0] IDX_PULLUP         = 6'h02;
    localparam logic [5:0] IDX_UPPER_DIR      = 6'h03;
    localparam logic [5:0] IDX_UPPER_DATA     = 6'h04;
    localparam logic [5:0] IDX_BUS_DATA       = 6'h06;
    localparam logic [5:0] IDX_BUS_DIR        = 6'h07;
    localparam logic [5:0] IDX_SERIAL_DATA    = 6'h08;
    localparam logic [5:0] IDX_SERIAL_DIR     = 6'h09;
    localparam logic [5:0] IDX_ANALOG_DATA    = 6'h0a;
    localparam logic [5:0] IDX_OPTIONS_TWO    = 6'h38;

    localparam int         ADDR_W             = 8;
    localparam logic [1:0] WORD_ALIGN         = 2'h0;

    // Field positions
    localparam int         OPT_OPEN_DRAIN_BIT = 6;
    localparam int         OPT_READ_VIS_BIT   = 4;
    localparam int         PULLUP_UPPER_BIT   = 0;

    // Reset values; data latches have no defined content, this pattern stands in
    localparam logic [7:0] LATCH_RESET        = 8'h00;
    localparam logic [7:0] DIR_RESET          = 8'h00;
    localparam logic [7:0] OPT_RESET          = 8'h00;
    localparam logic [7:0] ALL_ONES           = 8'hff;
    localparam logic [7:0] ALL_ZEROS          = 8'h00;

    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP,
        MODE_BOOTSTRAP,
        MODE_EXPANDED,
        MODE_TEST
    } mppio_mode_type;

    // Peripheral function claim on a port: enable, output enable, output level
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] oe;
        logic [7:0] out;
    } mppio_fn_type;

    // Expanded-bus side of the core
    typedef struct packed {
        logic [7:0] addr_hi;
        logic       wr_en;
        logic [7:0] wdata;
        logic       int_rd;
        logic [7:0] int_rdata;
    } mppio_bus_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } mppio_drive_type;

endpackage

/* hw/mppio_top.sv */
// Parallel I/O ports A to E with APB register access
//
// Contract
// - Direction bit 0 input, 1 output
// - Enabled peripheral function overrides direction bit
// - Writes latch; latches drive general-purpose outputs
// - Reads return actual pin level
// - Open-drain port C outputs read driver level
// - Reset: inputs, except bus ports expanded
// - Undriven latch content driven when output
// - First port: eight pins, direction cleared
// - Upper-address port carries address when expanded
// - Data-bus port carries data when expanded
// - Open-drain mode: drive low, float high
// - Read visibility drives internal reads out
// - Single-chip: visibility bit holds clock low
// - Visibility bit resets zero, written once
// - Analog port eight inputs, no direction
// - Upper-address port pullups under separate register
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module mppio_top
    import mppio_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire mppio_mode_type        chip_mode,
    input  wire mppio_fn_type          timer_fn,
    input  wire mppio_fn_type          serial_fn,
    input  wire mppio_bus_type         bus_side,
    input  wire logic                  e_clk_in,
    output logic                       e_clk_out,
    input  wire logic [7:0]            timer_port_pins_in,
    output logic      [7:0]            timer_port_pins_out,
    output logic      [7:0]            timer_port_pins_oe,
    input  wire logic [7:0]            upper_addr_pins_in,
    output logic      [7:0]            upper_addr_pins_out,
    output logic      [7:0]            upper_addr_pins_oe,
    output logic                       upper_addr_pullup_en,
    input  wire logic [7:0]            data_bus_pins_in,
    output logic      [7:0]            data_bus_pins_out,
    output logic      [7:0]            data_bus_pins_oe,
    input  wire logic [5:0]            serial_port_pins_in,
    output logic      [5:0]            serial_port_pins_out,
    output logic      [5:0]            serial_port_pins_oe,
    input  wire logic [7:0]            analog_input_pins
);

    typedef struct packed {
        logic [7:0]  first_port_direction;
        logic [7:0]  upper_address_port_direction;
        logic [7:0]  data_bus_port_direction;
        logic [5:0]  serial_port_direction;
        logic [7:0]  first_port_data;
        logic [7:0]  upper_address_port_data;
        logic [7:0]  data_bus_port_data;
        logic [5:0]  serial_port_data;
        logic [7:0]  system_options_two;
        logic [7:0]  pullup_assignment_reg;
        logic        vis_locked;
        mppio_drive_type pa;
        mppio_drive_type pb;
        mppio_drive_type pc;
        mppio_drive_type pd;
        logic        pb_pull;
        logic        e_clk;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } mppio_state_type;

    mppio_state_type state_reg;
    mppio_state_type state_next;

    // Index of an aligned, mapped register, or all ones when unmapped
    function automatic logic [6:0] reg_decode(input logic [ADDR_W-1:0] a);
        logic [5:0] idx;
        idx = a[ADDR_W-1:2];
        if (a[1:0] != WORD_ALIGN) begin
            return 7'h7f;
        end
        case (idx)
            IDX_FIRST_DATA, IDX_FIRST_DIR, IDX_PULLUP, IDX_UPPER_DIR,
            IDX_UPPER_DATA, IDX_BUS_DATA, IDX_BUS_DIR, IDX_SERIAL_DATA,
            IDX_SERIAL_DIR, IDX_ANALOG_DATA, IDX_OPTIONS_TWO: begin
                return {1'b0, idx};
            end
            default: begin
                return 7'h7f;
            end
        endcase
    endfunction

    // General-purpose drive with a peripheral claim taking precedence per pin
    function automatic mppio_drive_type pin_drive(input logic [7:0] dir,
                                                  input logic [7:0] lat,
                                                  input mppio_fn_type fn);
        mppio_drive_type d;
        d.oe  = (fn.en & fn.oe) | (~fn.en & dir);
        d.out = (fn.en & fn.out) | (~fn.en & lat);
        return d;
    endfunction

    logic       bus_mode;
    logic       open_drain;
    logic       read_vis;
    logic [6:0] acc_idx;
    logic       setup_phase;
    logic       write_done;
    logic [7:0] c_read;
    logic [7:0] rd_byte;

    assign bus_mode    = (chip_mode == MODE_EXPANDED) || (chip_mode == MODE_TEST);
    assign open_drain  = state_reg.system_options_two[OPT_OPEN_DRAIN_BIT];
    assign read_vis    = state_reg.system_options_two[OPT_READ_VIS_BIT];
    assign acc_idx     = reg_decode(paddr);
    assign setup_phase = psel && !penable;
    assign write_done  = psel && penable && pwrite && state_reg.pready
                         && !state_reg.pslverr;

    // Open-drain outputs report what the drivers present, not the wire
    assign c_read = (!bus_mode && open_drain)
                    ? ((state_reg.data_bus_port_direction & state_reg.data_bus_port_data)
                       | (~state_reg.data_bus_port_direction & data_bus_pins_in))
                    : data_bus_pins_in;

    always_comb begin
        rd_byte = ALL_ZEROS;
        case (acc_idx[5:0])
            IDX_FIRST_DATA:  rd_byte = timer_port_pins_in;
            IDX_FIRST_DIR:   rd_byte = state_reg.first_port_direction;
            IDX_PULLUP:      rd_byte = state_reg.pullup_assignment_reg;
            IDX_UPPER_DIR:   rd_byte = state_reg.upper_address_port_direction;
            IDX_UPPER_DATA:  rd_byte = upper_addr_pins_in;
            IDX_BUS_DATA:    rd_byte = c_read;
            IDX_BUS_DIR:     rd_byte = state_reg.data_bus_port_direction;
            IDX_SERIAL_DATA: rd_byte = {2'b00, serial_port_pins_in};
            IDX_SERIAL_DIR:  rd_byte = {2'b00, state_reg.serial_port_direction};
            IDX_ANALOG_DATA: rd_byte = analog_input_pins;
            IDX_OPTIONS_TWO: rd_byte = state_reg.system_options_two;
            default:         rd_byte = ALL_ZEROS;
        endcase
    end

    always_comb begin
        state_next = state_reg;

        // Answer is prepared in the setup cycle so pready is already high in access
        state_next.pready  = setup_phase;
        state_next.pslverr = setup_phase && acc_idx[6];
        state_next.prdata  = state_reg.prdata;
        if (setup_phase) begin
            state_next.prdata = (pwrite || acc_idx[6]) ? 32'h0000_0000
                                                       : {24'h00_0000, rd_byte};
        end

        if (write_done) begin
            case (acc_idx[5:0])
                IDX_FIRST_DATA:  state_next.first_port_data = pwdata[7:0];
                IDX_FIRST_DIR:   state_next.first_port_direction = pwdata[7:0];
                IDX_PULLUP:      state_next.pullup_assignment_reg = pwdata[7:0];
                IDX_UPPER_DIR:   state_next.upper_address_port_direction = pwdata[7:0];
                IDX_UPPER_DATA:  state_next.upper_address_port_data = pwdata[7:0];
                IDX_BUS_DATA:    state_next.data_bus_port_data = pwdata[7:0];
                IDX_BUS_DIR:     state_next.data_bus_port_direction = pwdata[7:0];
                IDX_SERIAL_DATA: state_next.serial_port_data = pwdata[5:0];
                IDX_SERIAL_DIR:  state_next.serial_port_direction = pwdata[5:0];
                IDX_OPTIONS_TWO: begin
                    state_next.system_options_two = pwdata[7:0];
                    // Only the first write after reset may change visibility
                    if (state_reg.vis_locked) begin
                        state_next.system_options_two[OPT_READ_VIS_BIT] = read_vis;
                    end
                    state_next.vis_locked = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Timer port
        state_next.pa = pin_drive(state_reg.first_port_direction,
                                  state_reg.first_port_data, timer_fn);

        // Upper-address port
        if (bus_mode) begin
            state_next.pb.out = bus_side.addr_hi;
            state_next.pb.oe  = ALL_ONES;
        end else begin
            state_next.pb.out = state_reg.upper_address_port_data;
            state_next.pb.oe  = state_reg.upper_address_port_direction;
        end
        // Pullups are pointless while the pins carry address
        state_next.pb_pull = state_reg.pullup_assignment_reg[PULLUP_UPPER_BIT]
                             && !bus_mode;

        // Data-bus port; an external write cycle wins over read visibility
        if (bus_mode) begin
            if (bus_side.wr_en) begin
                state_next.pc.out = bus_side.wdata;
                state_next.pc.oe  = ALL_ONES;
            end else if (read_vis && bus_side.int_rd) begin
                state_next.pc.out = bus_side.int_rdata;
                state_next.pc.oe  = ALL_ONES;
            end else begin
                state_next.pc.out = ALL_ZEROS;
                state_next.pc.oe  = ALL_ZEROS;
            end
        end else if (open_drain) begin
            state_next.pc.out = ALL_ZEROS;
            state_next.pc.oe  = state_reg.data_bus_port_direction
                                & ~state_reg.data_bus_port_data;
        end else begin
            state_next.pc.out = state_reg.data_bus_port_data;
            state_next.pc.oe  = state_reg.data_bus_port_direction;
        end

        // Serial port
        state_next.pd = pin_drive({2'b00, state_reg.serial_port_direction},
                                  {2'b00, state_reg.serial_port_data},
                                  serial_fn);
        state_next.pd.out[7:6] = 2'b00;
        state_next.pd.oe[7:6]  = 2'b00;

        // Bus clock output is held low in single-chip modes when visibility is set
        state_next.e_clk = (!bus_mode && read_vis) ? 1'b0 : e_clk_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg                              <= '0;
            state_reg.first_port_direction         <= DIR_RESET;
            state_reg.upper_address_port_direction <= DIR_RESET;
            state_reg.data_bus_port_direction      <= DIR_RESET;
            state_reg.serial_port_direction        <= DIR_RESET[5:0];
            state_reg.first_port_data              <= LATCH_RESET;
            state_reg.upper_address_port_data      <= LATCH_RESET;
            state_reg.data_bus_port_data           <= LATCH_RESET;
            state_reg.serial_port_data             <= LATCH_RESET[5:0];
            state_reg.system_options_two           <= OPT_RESET;
            state_reg.pullup_assignment_reg        <= ALL_ZEROS;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata               = state_reg.prdata;
    assign pready               = state_reg.pready;
    assign pslverr              = state_reg.pslverr;
    assign e_clk_out            = state_reg.e_clk;
    assign timer_port_pins_out  = state_reg.pa.out;
    assign timer_port_pins_oe   = state_reg.pa.oe;
    assign upper_addr_pins_out  = state_reg.pb.out;
    assign upper_addr_pins_oe   = state_reg.pb.oe;
    assign upper_addr_pullup_en = state_reg.pb_pull;
    assign data_bus_pins_out    = state_reg.pc.out;
    assign data_bus_pins_oe     = state_reg.pc.oe;
    assign serial_port_pins_out = state_reg.pd.out[5:0];
    assign serial_port_pins_oe  = state_reg.pd.oe[5:0];

    a_dir_drives_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.first_port_direction[0] && !timer_fn.en[0])
        |=> timer_port_pins_oe[0])
        else $error("output direction did not enable timer port drivers");

    a_fn_overrides_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (serial_fn.en[0] && serial_fn.oe[0] && !state_reg.serial_port_direction[0])
        |=> serial_port_pins_oe[0] && serial_port_pins_out[0] == $past(serial_fn.out[0]))
        else $error("serial function did not take over its pin");

    a_latch_drives_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.first_port_direction[3] && !timer_fn.en[3])
        |=> timer_port_pins_out[3] == $past(state_reg.first_port_data[3]))
        else $error("latch not driven on general-purpose output");

    a_read_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == {IDX_FIRST_DATA, WORD_ALIGN})
        |=> pready && prdata[7:0] == $past(timer_port_pins_in))
        else $error("port read did not return pin level");

    a_open_drain_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == {IDX_BUS_DATA, WORD_ALIGN} && !bus_mode
         && open_drain)
        |=> (prdata[7:0] & $past(state_reg.data_bus_port_direction))
            == ($past(state_reg.data_bus_port_data) & $past(state_reg.data_bus_port_direction)))
        else $error("open-drain read did not return driver levels");

    // Sampled reset keeps the release edge, where the ports are still held, out of the check
    a_bus_addr_out: assert property (@(posedge pclk) disable iff (!presetn)
        (presetn && bus_mode) |=> upper_addr_pins_oe == ALL_ONES
                     && upper_addr_pins_out == $past(bus_side.addr_hi))
        else $error("upper address not on pins in bus mode");

    a_open_drain_float: assert property (@(posedge pclk) disable iff (!presetn)
        (!bus_mode && open_drain && state_reg.data_bus_port_data[2])
        |=> !data_bus_pins_oe[2] ##0 data_bus_pins_out == ALL_ZEROS)
        else $error("open-drain pin driven for a one");

    a_read_vis_out: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_mode && read_vis && bus_side.int_rd && !bus_side.wr_en)
        |=> data_bus_pins_oe == ALL_ONES && data_bus_pins_out == $past(bus_side.int_rdata))
        else $error("internal read not made visible");

    a_clock_held_low: assert property (@(posedge pclk) disable iff (!presetn)
        (!bus_mode && read_vis)[*2] |=> !e_clk_out)
        else $error("bus clock not held low");

    a_vis_write_once: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.vis_locked && write_done) |=> $stable(read_vis))
        else $error("visibility bit changed after first write");

    a_serial_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == {IDX_SERIAL_DATA, WORD_ALIGN})
        |=> prdata[7:6] == 2'b00)
        else $error("serial port upper bits not zero");

endmodule

/* tb/mppio_pins.sv */
// Board model: resolves every pin from the device drive and the board drive
`timescale 1ns/1ps
module mppio_pins
    import mppio_pkg::*;
(
    input  wire mppio_drive_type drv [4],
    input  wire logic [7:0]      ext,
    input  wire logic [7:0]      c_ext_en,
    output logic      [7:0]      lvl [4]
);
    // Board drives only bits the device has released, so there is never contention
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            lvl[p] = (drv[p].oe & drv[p].out) | (~drv[p].oe & ext);
        end
        // Released data bus bits rest at the board pull-up unless pulled low
        lvl[2] = (drv[2].oe & drv[2].out) | (~drv[2].oe & ((c_ext_en & ext) | ~c_ext_en));
    end
endmodule

/* tb/mppio_tb.sv */
// Self-checking bench for the parallel I/O block against a reference model
`timescale 1ns/1ps
module mppio_tb
    import mppio_pkg::*;
;
    localparam logic [5:0] DATS [4] = '{IDX_FIRST_DATA, IDX_UPPER_DATA, IDX_BUS_DATA,
                                        IDX_SERIAL_DATA};
    localparam logic [5:0] DIRS [4] = '{IDX_FIRST_DIR, IDX_UPPER_DIR, IDX_BUS_DIR,
                                        IDX_SERIAL_DIR};
    logic            pclk = 1'b0, presetn = 1'b0, e_clk_in = 1'b0, e_clk_out, pull_en;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0]      paddr = 8'h00, ext = 8'h00, c_ext_en = 8'hff, analog = 8'h00;
    logic [7:0]      d, v, m, ce;
    logic [15:0]     e16;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    logic [7:0]      lvl [4];
    logic [7:0]      lat [4] = '{default: LATCH_RESET};
    mppio_mode_type  chip_mode = MODE_SINGLE_CHIP;
    mppio_fn_type    timer_fn = '0, serial_fn = '0;
    mppio_bus_type   bus_side = '0;
    wire mppio_drive_type drv [4];
    int              err_total = 0, check_count = 0;

    assign drv[3].out[7:6] = 2'b00;
    assign drv[3].oe[7:6]  = 2'b00;

    always #4 pclk = ~pclk;
    always @(posedge pclk) e_clk_in <= ~e_clk_in;

    mppio_top mppio_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_mode(chip_mode), .timer_fn(timer_fn), .serial_fn(serial_fn),
        .bus_side(bus_side), .e_clk_in(e_clk_in), .e_clk_out(e_clk_out),
        .timer_port_pins_in(lvl[0]), .timer_port_pins_out(drv[0].out),
        .timer_port_pins_oe(drv[0].oe), .upper_addr_pins_in(lvl[1]),
        .upper_addr_pins_out(drv[1].out), .upper_addr_pins_oe(drv[1].oe),
        .upper_addr_pullup_en(pull_en), .data_bus_pins_in(lvl[2]),
        .data_bus_pins_out(drv[2].out), .data_bus_pins_oe(drv[2].oe),
        .serial_port_pins_in(lvl[3][5:0]), .serial_port_pins_out(drv[3].out[5:0]),
        .serial_port_pins_oe(drv[3].oe[5:0]), .analog_input_pins(analog));

    mppio_pins mppio_pins_inst (.drv(drv), .ext(ext), .c_ext_en(c_ext_en), .lvl(lvl));

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] ad(input logic [5:0] i);
        return {i, WORD_ALIGN};
    endfunction

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= ($urandom << 8) | 32'(wd);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) begin
            err_total++;
            $display("Error at %0t: no pready", $time);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle;
        @(posedge pclk);
        @(negedge pclk);
    endtask

    // Expected {out on driven bits, oe} of a port in general-purpose mode
    function automatic logic [15:0] gp_exp(int p, logic [7:0] dir);
        mppio_fn_type f;
        logic [7:0]   oe;
        f  = (p == 0) ? timer_fn : (p == 3) ? serial_fn : '0;
        oe = ((f.en & f.oe) | (~f.en & dir)) & m;
        return {((f.en & f.out) | (~f.en & lat[p])) & oe, oe};
    endfunction

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict;
    end

    initial begin
        void'($urandom(82));
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        for (int p = 0; p < 4; p++) check(drv[p].oe, 8'h00);
        @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            apb(1'b0, ad(DIRS[p]), 8'h00);
            check(rd, DIR_RESET);
        end
        for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 4; r++) begin
                @(posedge pclk);
                m = (p == 3) ? 8'h3f : 8'hff;
                d = 8'($urandom) & m;
                chip_mode <= r[0] ? MODE_BOOTSTRAP : MODE_SINGLE_CHIP;
                ext       <= 8'($urandom);
                timer_fn  <= 24'($urandom);
                serial_fn <= 24'($urandom);
                // Direction first: the latch content goes out before this round's data write
                apb(1'b1, ad(DIRS[p]), d);
                settle;
                e16 = gp_exp(p, d);
                check({drv[p].out & drv[p].oe, drv[p].oe}, e16);
                v = 8'($urandom);
                apb(1'b1, ad(DATS[p]), v);
                lat[p] = v & m;
                settle;
                e16 = gp_exp(p, d);
                check({drv[p].out & drv[p].oe, drv[p].oe}, e16);
                apb(1'b0, ad(DATS[p]), 8'h00);
                check(rd, (e16[15:8] | (~e16[7:0] & ext)) & m);
                apb(1'b0, ad(DIRS[p]), 8'h00);
                check(rd, d);
            end
        end
        @(posedge pclk);
        timer_fn  <= '0;
        serial_fn <= '0;
        chip_mode <= MODE_SINGLE_CHIP;
        ce = 8'($urandom);
        ext       <= 8'h00;
        c_ext_en  <= ce;
        d = 8'($urandom);
        v = 8'($urandom);
        apb(1'b1, ad(IDX_OPTIONS_TWO), 8'h50);
        apb(1'b1, ad(IDX_BUS_DIR), d);
        apb(1'b1, ad(IDX_BUS_DATA), v);
        settle;
        check({drv[2].out & drv[2].oe, drv[2].oe}, {8'h00, d & ~v});
        check(e_clk_out, 1'b0);
        apb(1'b0, ad(IDX_BUS_DATA), 8'h00);
        check(rd, 8'((d & v) | (~d & ~ce)));
        apb(1'b1, ad(IDX_OPTIONS_TWO), 8'h00);
        apb(1'b0, ad(IDX_OPTIONS_TWO), 8'h00);
        check(rd, 32'h10);
        apb(1'b1, ad(IDX_PULLUP), 8'h01);
        settle;
        check(pull_en, 1'b1);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            c_ext_en  <= 8'hff;
            chip_mode <= k ? MODE_TEST : MODE_EXPANDED;
            bus_side  <= {8'($urandom), 1'b0, 8'($urandom), 1'b1, 8'($urandom)};
            settle;
            check({drv[1].out, drv[1].oe}, {bus_side.addr_hi, 8'hff});
            check({drv[2].out, drv[2].oe}, {bus_side.int_rdata, 8'hff});
            check(e_clk_out, 1'(~e_clk_in));
            check(pull_en, 1'b0);
            @(posedge pclk);
            bus_side.wr_en <= 1'b1;
            settle;
            check({drv[2].out, drv[2].oe}, {bus_side.wdata, 8'hff});
        end
        @(posedge pclk);
        presetn        <= 1'b0;
        bus_side.wr_en <= 1'b0;
        @(negedge pclk);
        check({drv[1].oe, drv[2].oe}, 16'h0000);
        @(posedge pclk);
        presetn <= 1'b1;
        settle;
        check({drv[1].oe, drv[2].oe}, 16'hff00);
        apb(1'b0, ad(IDX_OPTIONS_TWO), 8'h00);
        check(rd, 32'h0);
        apb(1'b1, ad(IDX_OPTIONS_TWO), 8'h10);
        settle;
        check(drv[2].oe, 8'hff);
        // No conversion is modelled, so the analog port is never read mid-sample
        @(posedge pclk);
        v = 8'($urandom);
        analog <= v;
        apb(1'b1, ad(IDX_ANALOG_DATA), ~v);
        check(er, 1'b0);
        apb(1'b0, ad(IDX_ANALOG_DATA), 8'h00);
        check(rd, v);
        apb(1'b0, 8'h14, 8'h00);
        check(er, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, 8'h01, 8'h00);
        check(er, 1'b1);
        give_verdict;
    end
endmodule
